// ===== include/sfad_pkg.sv
package sfad_pkg;
   localparam int unsigned SFAD_REF_MHZ = 20;
   localparam int unsigned SFAD_VCSL_US = 50;
   localparam int unsigned SFAD_VCSL_CYC = SFAD_VCSL_US * SFAD_REF_MHZ;
   localparam int unsigned SFAD_PUW_MS = 20;
   localparam int unsigned SFAD_PUW_CYC = SFAD_PUW_MS * 1000 * SFAD_REF_MHZ;
   localparam int SFAD_CNT_W = 19;
   localparam logic [18:0] SFAD_CNT_RST = 19'h00000;
   localparam int SFAD_PAGE_LSB = 9;
   localparam logic [8:0] SFAD_PG_ALL = 9'h1FF;
   localparam logic [8:0] SFAD_PG_HI5 = 9'h1F0;
   localparam logic [8:0] SFAD_NONE9 = 9'h000;
   localparam logic [1:0] SFAD_ADDR_BYTES = 2'h3;
   localparam logic SFAD_MODE3_RST = 1'b1;
   localparam logic [1:0] SFAD_Q_FALL = 2'h0;
   localparam logic [1:0] SFAD_Q_RISE = 2'h2;
   localparam logic [1:0] SFAD_CS_GAP = 2'h3;
   localparam logic [2:0] SFAD_BIT_LAST = 3'h7;

   localparam logic [7:0] OP_RD_ARRAY = 8'h03;
   localparam logic [7:0] OP_RD_FAST = 8'h0B;
   localparam logic [7:0] OP_BLK_ERASE = 8'h50;
   localparam logic [7:0] OP_PG_XFER = 8'h53;
   localparam logic [7:0] OP_PG_REWRITE = 8'h58;
   localparam logic [7:0] OP_PG_COMPARE = 8'h60;
   localparam logic [7:0] OP_RD_SECURE = 8'h77;
   localparam logic [7:0] OP_CHIP_ERASE = 8'h7C;
   localparam logic [7:0] OP_PG_ERASE = 8'h81;
   localparam logic [7:0] OP_PG_PROG = 8'h82;
   localparam logic [7:0] OP_BUF_PROG_E = 8'h83;
   localparam logic [7:0] OP_BUF_WR = 8'h84;
   localparam logic [7:0] OP_BUF_PROG = 8'h88;
   localparam logic [7:0] OP_ID_READ = 8'h9F;
   localparam logic [7:0] OP_DEEP_PD = 8'hB9;
   localparam logic [7:0] OP_RESUME = 8'hAB;
   localparam logic [7:0] OP_BUF_RD_LO = 8'hD1;
   localparam logic [7:0] OP_PG_READ = 8'hD2;
   localparam logic [7:0] OP_BUF_RD = 8'hD4;
   localparam logic [7:0] OP_STATUS = 8'hD7;
   localparam logic [7:0] OP_RD_CONT = 8'hE8;

   typedef enum logic [4:0] {
      PH_OPC = 5'h01, PH_ADDR = 5'h02, PH_DUMMY = 5'h04,
      PH_DATA = 5'h08, PH_SKIP = 5'h10
   } sfad_ph_t;

   typedef enum logic [4:0] {
      HS_WAIT = 5'h01, HS_IDLE = 5'h02, HS_SEL = 5'h04,
      HS_SHIFT = 5'h08, HS_GAP = 5'h10
   } sfad_hst_t;

   typedef struct packed {
      sfad_ph_t ph;
      logic [2:0] cnt;
      logic [2:0] left;
      logic [7:0] opc;
      logic [23:0] addr;
   } sfad_frm_t;
   localparam sfad_frm_t SFAD_FRM_RST = '{PH_OPC, 3'h0, 3'h0, 8'h00,
                                          24'h000000};

   typedef struct packed {
      logic tog;
      logic [7:0] opc;
      logic [8:0] page;
      logic [8:0] byte_a;
      logic blk;
   } sfad_rep_t;
   localparam sfad_rep_t SFAD_REP_RST = '{1'b0, 8'h00, 9'h000, 9'h000,
                                          1'b0};

   typedef struct packed {
      logic oe;
      logic so;
      logic [7:0] sh;
   } sfad_so_t;
   localparam sfad_so_t SFAD_SO_RST = '{1'b0, 1'b1, 8'h00};

   typedef struct packed {
      logic por;
      logic tog_d;
      logic [18:0] cnt;
      logic wr_ok;
      logic cmd_valid;
      logic [7:0] opc;
      logic [8:0] page;
      logic [8:0] byte_a;
      logic mode3;
      logic blk;
      logic standby;
   } sfad_dref_t;

   typedef struct packed {
      sfad_hst_t st;
      logic [1:0] q;
      logic [7:0] idx;
      logic [7:0] hdr;
      logic [7:0] total;
      logic [63:0] tx;
      logic [7:0] rx;
      logic [18:0] cnt;
      logic cs_n;
      logic sck;
      logic mosi;
      logic rd_valid;
      logic [7:0] rd_data;
      logic done;
      logic busy;
      logic ready;
      logic wr_ok;
   } sfad_host_t;

   function automatic logic [1:0] sfad_addr_bytes(input logic [7:0] op);
      if (op == OP_ID_READ || op == OP_DEEP_PD || op == OP_RESUME ||
          op == OP_STATUS)
         return 2'h0;
      return SFAD_ADDR_BYTES;
   endfunction

   function automatic logic [2:0] sfad_dummy(input logic [7:0] op);
      if (op == OP_RD_FAST || op == OP_BUF_RD)
         return 3'h1;
      if (op == OP_PG_READ || op == OP_RD_CONT)
         return 3'h4;
      return 3'h0;
   endfunction

   function automatic logic sfad_is_read(input logic [7:0] op);
      return op == OP_RD_ARRAY || op == OP_RD_FAST || op == OP_RD_SECURE ||
             op == OP_ID_READ || op == OP_BUF_RD_LO || op == OP_PG_READ ||
             op == OP_BUF_RD || op == OP_STATUS || op == OP_RD_CONT;
   endfunction

   function automatic logic sfad_is_write(input logic [7:0] op);
      return op == OP_BLK_ERASE || op == OP_PG_REWRITE ||
             op == OP_CHIP_ERASE || op == OP_PG_ERASE || op == OP_PG_PROG ||
             op == OP_BUF_PROG_E || op == OP_BUF_PROG;
   endfunction

   function automatic logic [8:0] sfad_page_mask(input logic [7:0] op);
      if (op == OP_BLK_ERASE)
         return SFAD_PG_HI5;
      if (op == OP_BUF_WR || op == OP_BUF_RD_LO || op == OP_BUF_RD ||
          op == OP_RD_SECURE || op == OP_CHIP_ERASE)
         return SFAD_NONE9;
      return SFAD_PG_ALL;
   endfunction

   function automatic logic [8:0] sfad_byte_mask(input logic [7:0] op);
      if (op == OP_RD_ARRAY || op == OP_RD_FAST || op == OP_PG_PROG ||
          op == OP_BUF_WR || op == OP_BUF_RD_LO || op == OP_PG_READ ||
          op == OP_BUF_RD || op == OP_RD_CONT)
         return SFAD_PG_ALL;
      return SFAD_NONE9;
   endfunction
endpackage

// ===== include/sfad_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface sfad_link_if;
   logic cs_n;
   logic sck;
   logic mosi;
   logic so;
   logic so_oe;
   logic so_pin;

   // undriven serial output floats high through a pull-up
   assign so_pin = so_oe ? so : 1'b1;

   modport dev(input cs_n, input sck, input mosi, output so, output so_oe);
   modport host(output cs_n, output sck, output mosi, input so_pin);
endinterface
`default_nettype wire

// ===== logic/sfad_sync.sv
`timescale 1ns/1ps
`default_nettype none
module sfad_sync #(
   parameter int W = 1
) (
   input wire logic i_clk,
   input wire logic [W-1:0] i_d,
   output logic [W-1:0] o_q
);
   logic [W-1:0] meta_r;
   logic [W-1:0] q_r;

   always_ff @(posedge i_clk) begin
      meta_r <= i_d;
      q_r <= meta_r;
   end

   assign o_q = q_r;
endmodule
`default_nettype wire

// ===== logic/sfad_dev.sv
`timescale 1ns/1ps
`default_nettype none
module sfad_dev
   import sfad_pkg::*;
#(
   parameter int unsigned PUW_CYC = SFAD_PUW_CYC
) (
   input wire logic i_ref_clk,
   input wire logic i_rst,
   sfad_link_if.dev link,
   input wire logic [7:0] i_rd_data,
   output logic o_cmd_valid,
   output logic [7:0] o_opcode,
   output logic [8:0] o_page,
   output logic [8:0] o_byte,
   output logic o_mode3,
   output logic o_wr_blocked,
   output logic o_standby
);
   localparam logic [18:0] PUW_END = 19'(PUW_CYC);

   sfad_frm_t frm_r;
   sfad_frm_t frm_nxt;
   sfad_rep_t rep_r;
   sfad_rep_t rep_nxt;
   sfad_so_t so_r;
   sfad_dref_t ref_r;
   sfad_dref_t ref_nxt;
   logic mode_cs_r;
   logic [9:0] lk_sync;
   logic por_s;
   logic wr_ok_s;
   logic [7:0] rd_s;
   logic tog_s;
   logic done;
   logic [7:0] opc_new;
   logic [23:0] addr_new;
   logic [7:0] out_byte;

   // quasi-static levels into the link domain; the first two link edges
   // of a frame may still see the old value
   sfad_sync #(.W(10)) u_lk_sync (
      .i_clk(link.sck),
      .i_d({ref_r.por, ref_r.wr_ok, i_rd_data}),
      .o_q(lk_sync)
   );
   assign por_s = lk_sync[9];
   assign wr_ok_s = lk_sync[8];
   assign rd_s = lk_sync[7:0];

   sfad_sync #(.W(1)) u_tog_sync (
      .i_clk(i_ref_clk),
      .i_d(rep_r.tog),
      .o_q(tog_s)
   );

   // link side: sampled on the rising clock
   always_comb begin
      frm_nxt = frm_r;
      rep_nxt = rep_r;
      done = 1'b0;
      opc_new = {frm_r.opc[6:0], link.mosi};
      addr_new = {frm_r.addr[22:0], link.mosi};
      frm_nxt.cnt = frm_r.cnt + 3'h1;
      case (frm_r.ph)
         PH_OPC: begin
            frm_nxt.opc = opc_new;
            if (frm_r.cnt == SFAD_BIT_LAST) begin
               frm_nxt.left = 3'(SFAD_ADDR_BYTES - 2'h1);
               if (por_s) begin
                  frm_nxt.ph = PH_SKIP;
               end else if (sfad_addr_bytes(opc_new) == 2'h0) begin
                  done = 1'b1;
                  frm_nxt.ph = sfad_is_read(opc_new) ? PH_DATA : PH_SKIP;
               end else begin
                  frm_nxt.ph = PH_ADDR;
               end
            end
         end
         PH_ADDR: begin
            frm_nxt.addr = addr_new;
            if (frm_r.cnt == SFAD_BIT_LAST) begin
               frm_nxt.left = frm_r.left - 3'h1;
               if (frm_r.left == 3'h0) begin
                  done = 1'b1;
                  frm_nxt.left = sfad_dummy(frm_r.opc) - 3'h1;
                  if (sfad_dummy(frm_r.opc) != 3'h0)
                     frm_nxt.ph = PH_DUMMY;
                  else if (sfad_is_read(frm_r.opc))
                     frm_nxt.ph = PH_DATA;
                  else
                     frm_nxt.ph = PH_SKIP;
               end
            end
         end
         PH_DUMMY: begin
            if (frm_r.cnt == SFAD_BIT_LAST) begin
               frm_nxt.left = frm_r.left - 3'h1;
               if (frm_r.left == 3'h0)
                  frm_nxt.ph = PH_DATA;
            end
         end
         PH_DATA: begin
         end
         default: begin
            frm_nxt.ph = PH_SKIP;
         end
      endcase
      if (done) begin
         rep_nxt.tog = ~rep_r.tog;
         rep_nxt.opc = (frm_r.ph == PH_OPC) ? opc_new : frm_r.opc;
         if (frm_r.ph == PH_OPC) begin
            rep_nxt.page = SFAD_NONE9;
            rep_nxt.byte_a = SFAD_NONE9;
         end else begin
            rep_nxt.page = addr_new[SFAD_PAGE_LSB +: 9] &
                           sfad_page_mask(frm_r.opc);
            rep_nxt.byte_a = addr_new[8:0] & sfad_byte_mask(frm_r.opc);
         end
         rep_nxt.blk = sfad_is_write(rep_nxt.opc) & ~wr_ok_s;
      end
   end

   // select high clears the frame even with the link clock stopped
   always_ff @(posedge link.sck or posedge link.cs_n) begin
      if (link.cs_n)
         frm_r <= SFAD_FRM_RST;
      else
         frm_r <= frm_nxt;
   end

   // power-on reset clears the report toggle with the link clock stopped;
   // it is released long before the host may select
   always_ff @(posedge link.sck or posedge ref_r.por) begin
      if (ref_r.por)
         rep_r <= SFAD_REP_RST;
      else
         rep_r <= rep_nxt;
   end

   always_ff @(negedge link.cs_n) begin
      mode_cs_r <= link.sck;
   end

   assign out_byte = (frm_r.opc == OP_STATUS) ? {wr_ok_s, 7'h00} : rd_s;

   // data leaves on the falling clock; the host samples it just before it drives the next falling clock
   always_ff @(negedge link.sck or posedge link.cs_n) begin
      if (link.cs_n) begin
         so_r <= SFAD_SO_RST;
      end else if (frm_r.ph == PH_DATA) begin
         so_r.oe <= 1'b1;
         if (frm_r.cnt == 3'h0) begin
            so_r.so <= out_byte[7];
            so_r.sh <= {out_byte[6:0], 1'b0};
         end else begin
            so_r.so <= so_r.sh[7];
            so_r.sh <= {so_r.sh[6:0], 1'b0};
         end
      end
   end

   assign link.so = so_r.so;
   assign link.so_oe = so_r.oe;

   // reference side: power-up timing and command report
   always_comb begin
      ref_nxt = ref_r;
      ref_nxt.por = 1'b0;
      ref_nxt.cmd_valid = 1'b0;
      ref_nxt.tog_d = tog_s;
      if (ref_r.cnt != PUW_END)
         ref_nxt.cnt = ref_r.cnt + 19'h1;
      else
         ref_nxt.wr_ok = 1'b1;
      ref_nxt.standby = 1'b1;
      // a toggle cleared by reset is no command
      if (tog_s != ref_r.tog_d && !ref_r.por) begin
         ref_nxt.cmd_valid = 1'b1;
         ref_nxt.opc = rep_r.opc;
         ref_nxt.page = rep_r.page;
         ref_nxt.byte_a = rep_r.byte_a;
         ref_nxt.blk = rep_r.blk;
         ref_nxt.mode3 = mode_cs_r;
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         ref_r <= '0;
         ref_r.por <= 1'b1;
         ref_r.tog_d <= tog_s;
         ref_r.cnt <= SFAD_CNT_RST;
         ref_r.mode3 <= SFAD_MODE3_RST;
      end else begin
         ref_r <= ref_nxt;
      end
   end

   assign o_cmd_valid = ref_r.cmd_valid;
   assign o_opcode = ref_r.opc;
   assign o_page = ref_r.page;
   assign o_byte = ref_r.byte_a;
   assign o_mode3 = ref_r.mode3;
   assign o_wr_blocked = ref_r.blk;
   assign o_standby = ref_r.standby;
endmodule
`default_nettype wire

// ===== logic/sfad_host.sv
`timescale 1ns/1ps
`default_nettype none
module sfad_host
   import sfad_pkg::*;
#(
   parameter int unsigned PUW_CYC = SFAD_PUW_CYC
) (
   input wire logic i_ref_clk,
   input wire logic i_rst,
   sfad_link_if.host link,
   input wire logic i_start,
   input wire logic [7:0] i_opcode,
   input wire logic [8:0] i_page,
   input wire logic [8:0] i_byte,
   input wire logic [3:0] i_rd_bytes,
   output logic o_busy,
   output logic o_ready,
   output logic o_wr_ok,
   output logic o_rd_valid,
   output logic [7:0] o_rd_data,
   output logic o_done
);
   localparam logic [18:0] PUW_END = 19'(PUW_CYC);
   localparam logic [18:0] VCSL_END = 19'(SFAD_VCSL_CYC);

   sfad_host_t h_r;
   sfad_host_t h_nxt;
   logic so_s;
   logic [7:0] rx_new;
   logic [7:0] past;

   sfad_sync #(.W(1)) u_so_sync (
      .i_clk(i_ref_clk),
      .i_d(link.so_pin),
      .o_q(so_s)
   );

   always_comb begin
      h_nxt = h_r;
      h_nxt.rd_valid = 1'b0;
      h_nxt.done = 1'b0;
      rx_new = {h_r.rx[6:0], so_s};
      past = h_r.idx - h_r.hdr;
      if (h_r.cnt != PUW_END)
         h_nxt.cnt = h_r.cnt + 19'h1;
      h_nxt.ready = h_r.cnt >= VCSL_END;
      h_nxt.wr_ok = h_r.cnt == PUW_END;
      case (h_r.st)
         HS_WAIT: begin
            if (h_r.ready)
               h_nxt.st = HS_IDLE;
         end
         HS_IDLE: begin
            if (i_start && (!sfad_is_write(i_opcode) || h_r.wr_ok)) begin
               h_nxt.st = HS_SEL;
               h_nxt.busy = 1'b1;
               h_nxt.cs_n = 1'b0;
               h_nxt.q = SFAD_Q_FALL;
               h_nxt.idx = 8'h00;
               h_nxt.hdr = 8'((32'(sfad_addr_bytes(i_opcode)) +
                              32'(sfad_dummy(i_opcode)) + 32'd1) * 8);
               h_nxt.total = h_nxt.hdr + {1'b0, i_rd_bytes, 3'h0};
               if (sfad_addr_bytes(i_opcode) == 2'h0)
                  h_nxt.tx = {i_opcode, 56'h0};
               else
                  h_nxt.tx = {i_opcode, 6'h00, i_page, i_byte, 32'h0};
            end
         end
         HS_SEL: begin
            h_nxt.st = HS_SHIFT;
         end
         HS_SHIFT: begin
            h_nxt.q = h_r.q + 2'h1;
            if (h_r.q == SFAD_Q_FALL) begin
               if (h_r.idx > h_r.hdr) begin
                  h_nxt.rx = rx_new;
                  if (past[2:0] == 3'h0) begin
                     h_nxt.rd_valid = 1'b1;
                     h_nxt.rd_data = rx_new;
                  end
               end
               if (h_r.idx == h_r.total) begin
                  h_nxt.st = HS_GAP;
                  h_nxt.cs_n = 1'b1;
                  h_nxt.q = SFAD_Q_FALL;
               end else begin
                  h_nxt.sck = 1'b0;
                  h_nxt.mosi = h_r.tx[63];
                  h_nxt.tx = {h_r.tx[62:0], 1'b0};
                  h_nxt.idx = h_r.idx + 8'h1;
               end
            end else if (h_r.q == SFAD_Q_RISE) begin
               h_nxt.sck = 1'b1;
            end
         end
         HS_GAP: begin
            h_nxt.q = h_r.q + 2'h1;
            if (h_r.q == SFAD_CS_GAP) begin
               h_nxt.st = HS_IDLE;
               h_nxt.busy = 1'b0;
               h_nxt.done = 1'b1;
            end
         end
         default: begin
            h_nxt.st = HS_WAIT;
         end
      endcase
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         h_r <= '0;
         h_r.st <= HS_WAIT;
         h_r.cnt <= SFAD_CNT_RST;
         h_r.cs_n <= 1'b1;
         h_r.sck <= 1'b1; // mode 3 idle level
      end else begin
         h_r <= h_nxt;
      end
   end

   assign link.cs_n = h_r.cs_n;
   assign link.sck = h_r.sck;
   assign link.mosi = h_r.mosi;
   assign o_busy = h_r.busy;
   assign o_ready = h_r.ready;
   assign o_wr_ok = h_r.wr_ok;
   assign o_rd_valid = h_r.rd_valid;
   assign o_rd_data = h_r.rd_data;
   assign o_done = h_r.done;
endmodule
`default_nettype wire

// ===== verification/sfad_link_props.sv
`timescale 1ns/1ps
`default_nettype none
module sfad_link_props
   import sfad_pkg::*;
(
   input wire logic i_ref_clk,
   input wire logic i_rst,
   input wire logic cs_n,
   input wire logic sck,
   input wire logic mosi,
   input wire logic so_oe
);
   logic [10:0] since_rst_r;
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (i_rst);
   // saturates: only the first thousand cycles matter
   always_ff @(posedge i_ref_clk) begin
      if (i_rst)
         since_rst_r <= 11'h000;
      else if (since_rst_r != 11'h7FF)
         since_rst_r <= since_rst_r + 11'h001;
   end
   chk_reset_float: assert property (disable iff (1'b0)
      i_rst [*2] |-> !so_oe) else $error("output driven in reset");
   chk_reset_deselect: assert property (disable iff (1'b0)
      i_rst [*2] |-> cs_n && sck) else $error("link active in reset");
   chk_oe_needs_select: assert property (
      so_oe |-> !cs_n) else $error("output driven while deselected");
   chk_oe_on_fall: assert property (
      $rose(so_oe) |-> $fell(sck)) else $error("output not on falling sck");
   chk_sck_idle_high: assert property (
      cs_n |-> sck) else $error("link clock idles low");
   chk_sel_gap: assert property (
      $rose(cs_n) |-> cs_n [*4]) else $error("select high too short");
   chk_ready_delay: assert property (
      $fell(cs_n) |-> {21'h00000, since_rst_r} >= SFAD_VCSL_CYC)
      else $error("selected too soon after reset");
   chk_mosi_changes_low: assert property (
      !cs_n && !$past(cs_n) && $changed(mosi) |-> !sck)
      else $error("data moved while clock high");
   cov_select: cover property ($fell(cs_n));
   cov_drive: cover property ($rose(so_oe));
   cov_frame_end: cover property ($rose(cs_n) ##4 cs_n);
endmodule
`default_nettype wire

// ===== verification/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
   localparam int unsigned H_PUW = 1200;
   localparam int unsigned D_PUW = 3000;
   localparam logic [8:0] PG = 9'h1A5;
   localparam logic [8:0] BY = 9'h15A;
   localparam logic [7:0] OPS [21] = '{8'h03, 8'h0B, 8'h50, 8'h53, 8'h58,
      8'h60, 8'h77, 8'h7C, 8'h81, 8'h82, 8'h83, 8'h84, 8'h88, 8'h9F, 8'hB9,
      8'hAB, 8'hD1, 8'hD2, 8'hD4, 8'hD7, 8'hE8};
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic start = 1'b0;
   logic [7:0] opc = 8'h00;
   logic [3:0] nrd = 4'h0;
   logic cv, m3, wrb, sby, busy, rdy, wok, rv, done;
   logic [7:0] rep_op, rd, r_op, exp_rd;
   logic [8:0] rep_pg, rep_by, r_pg, r_by;
   logic r_m3, r_wb;
   logic [31:0] w_bits;
   int nrise, oe_at, rep_n, rd_n, rd_err, cyc;
   int bad_count = 0;
   int n_checks = 0;
   sfad_link_if lnk();
   sfad_dev #(.PUW_CYC(D_PUW)) i_sfad_dev (.i_ref_clk(clk), .i_rst(rst),
      .link(lnk), .i_rd_data(8'hC3), .o_cmd_valid(cv), .o_opcode(rep_op),
      .o_page(rep_pg), .o_byte(rep_by), .o_mode3(m3), .o_wr_blocked(wrb),
      .o_standby(sby));
   sfad_host #(.PUW_CYC(H_PUW)) i_sfad_host (.i_ref_clk(clk), .i_rst(rst),
      .link(lnk), .i_start(start), .i_opcode(opc), .i_page(PG), .i_byte(BY),
      .i_rd_bytes(nrd), .o_busy(busy), .o_ready(rdy), .o_wr_ok(wok),
      .o_rd_valid(rv), .o_rd_data(rd), .o_done(done));
   sfad_link_props i_sfad_link_props (.i_ref_clk(clk), .i_rst(rst),
      .cs_n(lnk.cs_n), .sck(lnk.sck), .mosi(lnk.mosi), .so_oe(lnk.so_oe));
   always #25 clk = ~clk;
   // the wire itself is judged, not only what each end reports
   always @(negedge lnk.cs_n) begin
      nrise = 0;
      oe_at = 255;
   end
   always @(posedge lnk.sck) if (lnk.cs_n === 1'b0) begin
      if (nrise < 32)
         w_bits[31 - nrise] = lnk.mosi;
      nrise = nrise + 1;
   end
   always @(posedge lnk.so_oe) oe_at = nrise;
   always @(posedge clk) begin
      cyc <= rst ? 0 : cyc + 1;
      if (cv === 1'b1) begin
         rep_n <= rep_n + 1;
         r_op <= rep_op;
         r_pg <= rep_pg;
         r_by <= rep_by;
         r_m3 <= m3;
         r_wb <= wrb;
      end
      if (rv === 1'b1) begin
         rd_n <= rd_n + 1;
         if (rd !== exp_rd)
            rd_err <= rd_err + 1;
      end
   end
   task automatic wrap_up();
      if (bad_count == 0 && n_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wait_sig(input int w, input int lim);
      int k;
      k = 0;
      while ((w == 0 ? rdy : w == 1 ? busy : w == 2 ? done : wok) !== 1'b1)
      begin
         if (k >= lim) begin
            chk("wait", 1, 0);
            wrap_up();
         end
         @(posedge clk);
         #1;
         k++;
      end
   endtask
   task automatic run(input logic [7:0] op);
      int a, d, n;
      logic [8:0] pm, bm;
      logic exp_wb;
      a = (op inside {8'h9F, 8'hB9, 8'hAB, 8'hD7}) ? 0 : 3;
      d = (op inside {8'h0B, 8'hD4}) ? 1 : (op inside {8'hD2, 8'hE8}) ? 4 : 0;
      n = (op == 8'hD7) ? 1 : (op inside {8'h03, 8'h0B, 8'h77, 8'h9F, 8'hD1,
         8'hD2, 8'hD4, 8'hE8}) ? 2 : 0;
      pm = (op == 8'h50) ? 9'h1F0 : (op inside {8'h84, 8'hD1, 8'hD4, 8'h77,
         8'h7C} || a == 0) ? 9'h000 : 9'h1FF;
      bm = (op inside {8'h03, 8'h0B, 8'h82, 8'h84, 8'hD1, 8'hD2, 8'hD4,
         8'hE8}) ? 9'h1FF : 9'h000;
      exp_rd = (op != 8'hD7) ? 8'hC3 : (cyc >= D_PUW) ? 8'h80 : 8'h00;
      exp_wb = (op inside {8'h50, 8'h58, 8'h7C, 8'h81, 8'h82, 8'h83, 8'h88})
         && cyc < D_PUW;
      pm = pm & PG;
      bm = bm & BY;
      rep_n = 0;
      rd_n = 0;
      rd_err = 0;
      opc = op;
      nrd = n[3:0];
      start = 1'b1;
      wait_sig(1, 4);
      start = 1'b0;
      wait_sig(2, 1500);
      chk("blocked", exp_wb, r_wb);
      repeat (6) @(posedge clk);
      #1;
      chk("reports", 1, rep_n);
      chk("opcode", op, r_op);
      chk("page", pm, r_pg);
      chk("byte", bm, r_by);
      chk("mode3", 1, r_m3);
      chk("rises", 8 * (1 + a + d + n), nrise);
      chk("drive at", n ? 8 * (1 + a + d) : 255, oe_at);
      chk("opcode bits", op, w_bits[31:24]);
      if (a != 0)
         chk("addr bits", {6'h00, PG, BY}, w_bits[23:0]);
      chk("data count", n, rd_n);
      chk("data bad", 0, rd_err);
   endtask
   initial begin
      repeat (3) @(posedge clk);
      #1;
      chk("mode3 rst", 1, m3);
      chk("oe rst", 0, lnk.so_oe);
      rst = 1'b0;
      @(posedge clk);
      #1;
      chk("standby", 1, sby);
      wait_sig(0, 1100);
      chk("ready late", 1, cyc >= 1000);
      opc = 8'h82;
      start = 1'b1;
      repeat (20) @(posedge clk);
      #1;
      chk("early write", 0, busy);
      run(8'hD7);
      wait_sig(3, 400);
      run(8'h83);
      while (cyc < D_PUW) @(posedge clk);
      #1;
      foreach (OPS[i]) run(OPS[i]);
      opc = 8'h0B;
      nrd = 4'hF;
      start = 1'b1;
      wait_sig(1, 4);
      start = 1'b0;
      rep_n = 0;
      repeat (60) @(posedge clk);
      #1;
      rst = 1'b1;
      repeat (3) @(posedge clk);
      #1;
      chk("cut reports", 0, rep_n);
      chk("oe cut", 0, lnk.so_oe);
      chk("mode3 again", 1, m3);
      rst = 1'b0;
      wait_sig(0, 1100);
      run(8'hD7);
      wrap_up();
   end
endmodule
`default_nettype wire
